// >>> logic/cmsi_top.sv
// Purpose: mode status word and interrupt flags of a CAN controller core
// Assumes: engine inputs are pulses or levels on mclk_i, no synchronising needed
// Notes: read data stand one cycle after rd_i; irq_o follows flags by one cycle
`timescale 1ns/1ps

// Summary of operation
// RQ1: bus active bit 5 is 1 while a frame moves, 0 in config or idle.
// RQ2: bus quiet bit 4 is 1 with no bus traffic, 0 in config or busy.
// RQ3: status bit 3 is 1 exactly while in normal mode.
// RQ4: status bit 2 is 1 exactly while in sleep mode.
// RQ5: status bit 1 is 1 exactly while in loopback mode.
// RQ6: status bit 0 is 1 in configuration mode and out of reset.
// RQ7: all interrupt conditions share one interrupt output.
// RQ8: each condition sets its sticky flag until cleared.
// RQ9: interrupt rises when any flag and its mask bit are both set.
// RQ10: software clears flags by writing ones to the clear register.
// RQ11: a set in the same cycle as a clear keeps the flag at 1.
// RQ12: core enable write of 0 clears wake, doze, bus-off, error, overflow, rx/tx ok, arb lost.
// RQ13: not-empty, underflow and both full flags clear only via clear register.
// RQ14: a loopback frame sets received flag, then sent flag one cycle later.
// RQ15: flag register bits 31 to 12 read zero and ignore writes.
module cmsi_top (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [cmsi_pkg::ADDR_W-1:0] addr_i,
  input wire logic [cmsi_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rx_busy_i,
  input wire logic tx_busy_i,
  input wire logic rx_done_i,
  input wire logic tx_done_i,
  input wire logic lb_frame_i,
  input wire logic arb_lost_i,
  input wire logic tx_fifo_full_i,
  input wire logic prio_buf_full_i,
  input wire logic rx_not_empty_i,
  input wire logic rx_underflow_i,
  input wire logic rx_overflow_i,
  input wire logic bus_err_i,
  input wire logic bus_off_i,
  output logic [cmsi_pkg::DATA_W-1:0] rdata_o,
  output logic irq_o,
  output logic cfg_mode_o,
  output logic loopback_o,
  output logic sleep_o
);
  import cmsi_pkg::*;

  logic [CTRL_W-1:0] ctrl_r;
  logic [CTRL_W-1:0] ctrl_nxt;
  logic [NFLAG-1:0] mask_r;
  logic [NFLAG-1:0] mask_nxt;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [NFLAG-1:0] clr_req;
  logic [NFLAG-1:0] clr_vec;
  logic [NFLAG-1:0] set_vec;
  logic [NFLAG-1:0] flags;
  logic ena_off;
  cmsi_mode_t mode_r;
  cmsi_mode_t mode_nxt;
  logic [STAT_W-1:0] stat_r;
  logic [STAT_W-1:0] stat_nxt;
  logic lb_pend_r;
  logic lb_pend_nxt;
  logic irq_r;
  logic irq_nxt;
  logic wake_evt;
  logic doze_evt;
  logic bus_busy;

  assign bus_busy = rx_busy_i | tx_busy_i;

  // register writes and read data
  always_comb begin
    ctrl_nxt = ctrl_r;
    mask_nxt = mask_r;
    rdata_nxt = '0;
    clr_req = '0;
    ena_off = 1'b0;
    if (wr_i) begin
      case (addr_i)
        OFF_CTRL: begin
          ctrl_nxt = wdata_i[CTRL_W-1:0];
          ena_off = ~wdata_i[CTRL_ENA]; // [RQ12]
        end
        OFF_IMASK: mask_nxt = wdata_i[NFLAG-1:0];
        OFF_ICLR: clr_req = wdata_i[NFLAG-1:0]; // [RQ10]
        default: ;
      endcase
    end
    if (rd_i) begin
      case (addr_i)
        OFF_CTRL: rdata_nxt = {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
        OFF_STATUS: rdata_nxt = {{(DATA_W-STAT_W){1'b0}}, stat_r};
        OFF_IFLAGS: rdata_nxt = {{(DATA_W-NFLAG){1'b0}}, flags}; // [RQ15]
        OFF_IMASK: rdata_nxt = {{(DATA_W-NFLAG){1'b0}}, mask_r};
        default: rdata_nxt = '0; // unmapped and clear register read zero
      endcase
    end
  end

  // register port storage
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctrl_r <= CTRL_RST;
      mask_r <= MASK_RST;
      rdata_r <= '0;
    end else begin
      ctrl_r <= ctrl_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // mode sequencing; the loopback request is taken only on leaving config, the doze request in normal mode
  always_comb begin
    mode_nxt = mode_r;
    wake_evt = 1'b0;
    doze_evt = 1'b0;
    case (mode_r)
      MODE_CFG: begin
        if (ctrl_r[CTRL_ENA]) begin
          mode_nxt = ctrl_r[CTRL_LPB] ? MODE_LPB : MODE_NRM;
        end
      end
      MODE_NRM: begin
        if (!ctrl_r[CTRL_ENA]) begin
          mode_nxt = MODE_CFG;
        end else if (ctrl_r[CTRL_DOZE] && !bus_busy) begin
          mode_nxt = MODE_DOZE;
          doze_evt = 1'b1;
        end
      end
      MODE_DOZE: begin
        if (!ctrl_r[CTRL_ENA]) begin
          mode_nxt = MODE_CFG;
        end else if (bus_busy || !ctrl_r[CTRL_DOZE]) begin
          mode_nxt = MODE_NRM; // bus traffic or software wakes the core
          wake_evt = 1'b1;
        end
      end
      MODE_LPB: begin
        if (!ctrl_r[CTRL_ENA]) begin
          mode_nxt = MODE_CFG;
        end
      end
      default: mode_nxt = MODE_CFG;
    endcase
    stat_nxt = '0;
    stat_nxt[ST_CONFIG] = (mode_nxt == MODE_CFG); // [RQ6]
    stat_nxt[ST_LOOPBACK] = (mode_nxt == MODE_LPB); // [RQ5]
    stat_nxt[ST_SLEEP] = (mode_nxt == MODE_DOZE); // [RQ4]
    stat_nxt[ST_NORMAL] = (mode_nxt == MODE_NRM); // [RQ3]
    stat_nxt[ST_QUIET] = (mode_nxt != MODE_CFG) && !bus_busy; // [RQ2]
    stat_nxt[ST_ACTIVE] = (mode_nxt != MODE_CFG) && bus_busy; // [RQ1]
    lb_pend_nxt = (mode_r == MODE_LPB) && lb_frame_i; // [RQ14]
  end

  // mode and status storage
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_r <= MODE_CFG;
      stat_r <= STAT_RST; // [RQ6]
      lb_pend_r <= 1'b0;
    end else begin
      mode_r <= mode_nxt;
      stat_r <= stat_nxt;
      lb_pend_r <= lb_pend_nxt;
    end
  end

  // event and clear vectors for the flag bank
  always_comb begin
    set_vec = '0;
    set_vec[FL_ARB] = arb_lost_i;
    set_vec[FL_TXGOOD] = tx_done_i | lb_pend_r; // [RQ14] sent follows received
    set_vec[FL_TXFULL] = tx_fifo_full_i;
    set_vec[FL_PRIOFULL] = prio_buf_full_i;
    set_vec[FL_RXGOOD] = rx_done_i | ((mode_r == MODE_LPB) && lb_frame_i); // [RQ14]
    set_vec[FL_RXUF] = rx_underflow_i;
    set_vec[FL_RXOF] = rx_overflow_i;
    set_vec[FL_RXNE] = rx_not_empty_i;
    set_vec[FL_ERR] = bus_err_i;
    set_vec[FL_BUSOFF] = bus_off_i;
    set_vec[FL_DOZE] = doze_evt;
    set_vec[FL_WAKE] = wake_evt; // [RQ8]
    clr_vec = clr_req | (ena_off ? FLAG_ENA_CLR : '0); // [RQ12] [RQ13]
  end

  // sticky flags
  cmsi_flags u_flags (
    .mclk_i(mclk_i),
    .reset_n_i(reset_n_i),
    .set_i(set_vec),
    .clr_i(clr_vec),
    .flags_o(flags)
  );

  // single interrupt line from enabled flags
  always_comb begin
    irq_nxt = |(flags & mask_r); // [RQ7] [RQ9]
  end

  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  // outputs straight from flip-flops
  assign rdata_o = rdata_r;
  assign irq_o = irq_r;
  assign cfg_mode_o = stat_r[ST_CONFIG];
  assign loopback_o = stat_r[ST_LOOPBACK];
  assign sleep_o = stat_r[ST_SLEEP];

  // checks on status and flag behaviour
  property p_active;
    @(posedge mclk_i) disable iff (!reset_n_i)
    stat_r[ST_ACTIVE] == ($past(bus_busy) && (mode_r != MODE_CFG));
  endproperty
  a_active: assert property (p_active) else $error("bus active bit wrong"); // [RQ1]

  property p_quiet;
    @(posedge mclk_i) disable iff (!reset_n_i)
    stat_r[ST_QUIET] == (!$past(bus_busy) && (mode_r != MODE_CFG));
  endproperty
  a_quiet: assert property (p_quiet) else $error("bus quiet bit wrong"); // [RQ2]

  property p_normal;
    @(posedge mclk_i) disable iff (!reset_n_i)
    stat_r[ST_NORMAL] == (mode_r == MODE_NRM);
  endproperty
  a_normal: assert property (p_normal) else $error("normal bit wrong"); // [RQ3]

  property p_sleep;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (ctrl_r[CTRL_ENA] && ctrl_r[CTRL_DOZE] && mode_r == MODE_NRM && !bus_busy)
      |=> stat_r[ST_SLEEP] && sleep_o && flags[FL_DOZE];
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep entry not shown"); // [RQ4]

  property p_loopback;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (mode_r == MODE_CFG && ctrl_r[CTRL_ENA] && ctrl_r[CTRL_LPB]) |=> loopback_o;
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback bit wrong"); // [RQ5]

  property p_config;
    @(posedge mclk_i) disable iff (!reset_n_i)
    $fell(ctrl_r[CTRL_ENA]) |=> cfg_mode_o && !stat_r[ST_ACTIVE] && !stat_r[ST_QUIET];
  endproperty
  a_config: assert property (p_config) else $error("config bit wrong"); // [RQ6]

  property p_irq;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ((flags & mask_r) != '0) |=> irq_o;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // [RQ9]

  property p_irq_quiet;
    @(posedge mclk_i) disable iff (!reset_n_i)
    ((flags & mask_r) == '0) |=> !irq_o;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet) else $error("irq without cause"); // [RQ7]

  property p_event;
    @(posedge mclk_i) disable iff (!reset_n_i)
    bus_off_i |=> flags[FL_BUSOFF];
  endproperty
  a_event: assert property (p_event) else $error("event flag not set"); // [RQ8]

  property p_ena_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (wr_i && addr_i == OFF_CTRL && !wdata_i[CTRL_ENA] && set_vec == '0)
      |=> ((flags & FLAG_ENA_CLR) == '0);
  endproperty
  a_ena_clear: assert property (p_ena_clear) else $error("disable left flags"); // [RQ12]

  property p_ena_keep;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (clr_req == '0) |=> ((flags & ~FLAG_ENA_CLR & $past(flags)) == ($past(flags) & ~FLAG_ENA_CLR));
  endproperty
  a_ena_keep: assert property (p_ena_keep) else $error("fifo flag lost"); // [RQ13]

  property p_lb_order;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (mode_r == MODE_LPB && lb_frame_i && clr_vec == '0)
      |=> flags[FL_RXGOOD] && set_vec[FL_TXGOOD] ##1 flags[FL_TXGOOD];
  endproperty
  a_lb_order: assert property (p_lb_order) else $error("loopback order wrong"); // [RQ14]

  property p_upper_zero;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == OFF_IFLAGS) |=> (rdata_o[DATA_W-1:NFLAG] == '0);
  endproperty
  a_upper_zero: assert property (p_upper_zero) else $error("upper flag bits set"); // [RQ15]
endmodule : cmsi_top

// >>> logic/cmsi_pkg.sv
// Purpose: constants shared by the mode status and interrupt flag block
// Assumes: one 32-bit register port with byte addresses
// Notes: offsets are word aligned; unused bits read as zero
package cmsi_pkg;
  // register port widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NFLAG = 12;
  localparam int CTRL_W = 3;
  localparam int STAT_W = 6;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_IFLAGS = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IMASK = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_ICLR = 8'h10;

  // control register fields
  localparam int CTRL_ENA = 0;
  localparam int CTRL_LPB = 1;
  localparam int CTRL_DOZE = 2;

  // core_mode_status fields
  localparam int ST_CONFIG = 0;
  localparam int ST_LOOPBACK = 1;
  localparam int ST_SLEEP = 2;
  localparam int ST_NORMAL = 3;
  localparam int ST_QUIET = 4;
  localparam int ST_ACTIVE = 5;

  // interrupt_flags fields
  localparam int FL_ARB = 0;
  localparam int FL_TXGOOD = 1;
  localparam int FL_TXFULL = 2;
  localparam int FL_PRIOFULL = 3;
  localparam int FL_RXGOOD = 4;
  localparam int FL_RXUF = 5;
  localparam int FL_RXOF = 6;
  localparam int FL_RXNE = 7;
  localparam int FL_ERR = 8;
  localparam int FL_BUSOFF = 9;
  localparam int FL_DOZE = 10;
  localparam int FL_WAKE = 11;

  // flags that a write of 0 to the core enable bit also clears
  localparam logic [NFLAG-1:0] FLAG_ENA_CLR = 12'hf53;

  // reset values
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h0;
  localparam logic [STAT_W-1:0] STAT_RST = 6'h01;
  localparam logic [NFLAG-1:0] FLAGS_RST = 12'h000;
  localparam logic [NFLAG-1:0] MASK_RST = 12'h000;

  // operating modes
  typedef enum logic [1:0] {MODE_CFG, MODE_NRM, MODE_LPB, MODE_DOZE} cmsi_mode_t;
endpackage : cmsi_pkg

// >>> logic/cmsi_flags.sv
// Purpose: bank of sticky interrupt flags
// Assumes: set and clear vectors are one-cycle pulses on mclk_i
// Notes: a set in the same cycle as a clear leaves the flag at 1
`timescale 1ns/1ps

module cmsi_flags (
  input wire logic mclk_i,
  input wire logic reset_n_i,
  input wire logic [cmsi_pkg::NFLAG-1:0] set_i,
  input wire logic [cmsi_pkg::NFLAG-1:0] clr_i,
  output logic [cmsi_pkg::NFLAG-1:0] flags_o
);
  import cmsi_pkg::*;

  logic [NFLAG-1:0] flags_r;
  logic [NFLAG-1:0] flags_nxt;

  // one sticky cell per flag
  genvar gi;
  generate
    for (gi = 0; gi < NFLAG; gi++) begin : g_flag
      always_comb begin
        flags_nxt[gi] = set_i[gi] | (flags_r[gi] & ~clr_i[gi]); // [RQ8] [RQ10] [RQ11]
      end
    end
  endgenerate

  // flag storage
  always_ff @(posedge mclk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags_o = flags_r;

  property p_set_wins;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (set_i != '0) |=> ((flags_r & $past(set_i)) == $past(set_i));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set flag not held"); // [RQ11]

  property p_clear;
    @(posedge mclk_i) disable iff (!reset_n_i)
    (clr_i != '0) |=> ((flags_r & $past(clr_i) & ~$past(set_i)) == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("cleared flag still set"); // [RQ10]
endmodule : cmsi_flags

// >>> tb/tb_top.sv
// Purpose: self-checking bench for the mode status and interrupt flag block
// Assumes: register reads answer one cycle after rd_i, irq_o one cycle behind flags
// Notes: model state is kept in ints; register reads are compared with it or with fixed expected values
`timescale 1ns/1ps

module tb_top;
  import cmsi_pkg::*;
  logic mclk_i, reset_n_i, wr_i, rd_i, irq_o, cfg_mode_o, loopback_o, sleep_o;
  logic [ADDR_W-1:0] addr_i;
  logic [DATA_W-1:0] wdata_i, rdata_o;
  logic rx_busy_i, tx_busy_i, rx_done_i, tx_done_i, lb_frame_i, arb_lost_i, bus_err_i;
  logic tx_fifo_full_i, prio_buf_full_i, rx_not_empty_i, rx_underflow_i, rx_overflow_i;
  logic bus_off_i;
  int fail_count, comparisons, flags_m, mask_m, mode_m, busy_m;

  cmsi_top cmsi_top_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rx_busy_i(rx_busy_i),
    .tx_busy_i(tx_busy_i), .rx_done_i(rx_done_i), .tx_done_i(tx_done_i),
    .lb_frame_i(lb_frame_i), .arb_lost_i(arb_lost_i), .tx_fifo_full_i(tx_fifo_full_i),
    .prio_buf_full_i(prio_buf_full_i), .rx_not_empty_i(rx_not_empty_i),
    .rx_underflow_i(rx_underflow_i), .rx_overflow_i(rx_overflow_i), .bus_err_i(bus_err_i),
    .bus_off_i(bus_off_i), .rdata_o(rdata_o), .irq_o(irq_o), .cfg_mode_o(cfg_mode_o),
    .loopback_o(loopback_o), .sleep_o(sleep_o));

  // 10 MHz clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end

  task automatic wrap_up();
    $display("mismatches %0d comparisons %0d", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // idle cycles, ending just after an edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : tick

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask : wr

  // read, data taken in the cycle after the strobe
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, exp);
  endtask : rchk

  // engine event input for a flag position
  task automatic drive(input int b, input logic v);
    case (b)
      0: arb_lost_i <= v;
      1: tx_done_i <= v;
      2: tx_fifo_full_i <= v;
      3: prio_buf_full_i <= v;
      4: rx_done_i <= v;
      5: rx_underflow_i <= v;
      6: rx_overflow_i <= v;
      7: rx_not_empty_i <= v;
      8: bus_err_i <= v;
      default: bus_off_i <= v;
    endcase
  endtask : drive

  task automatic pulse(input int b);
    @(posedge mclk_i);
    drive(b, 1'b1);
    @(posedge mclk_i);
    drive(b, 1'b0);
    flags_m |= 1 << b;
  endtask : pulse

  // expected status word from model mode and bus state
  function automatic logic [DATA_W-1:0] exp_st();
    case (mode_m)
      0: return 32'h01;
      1: return (busy_m != 0) ? 32'h28 : 32'h18;
      2: return (busy_m != 0) ? 32'h22 : 32'h12;
      default: return 32'h14;
    endcase
  endfunction : exp_st

  // watchdog
  initial begin
    repeat (20000) @(posedge mclk_i);
    fail_count++;
    wrap_up();
  end

  // main sequence
  initial begin
    {wr_i, rd_i, rx_busy_i, tx_busy_i, rx_done_i, tx_done_i, lb_frame_i} = 7'h00;
    {arb_lost_i, tx_fifo_full_i, prio_buf_full_i, rx_not_empty_i} = 4'h0;
    {rx_underflow_i, rx_overflow_i, bus_err_i, bus_off_i} = 4'h0;
    addr_i = 8'h00;
    wdata_i = 32'h0;
    reset_n_i = 1'b0;
    fail_count = 0;
    comparisons = 0;
    flags_m = 0;
    mode_m = 0;
    busy_m = 0;
    void'($urandom(23));
    repeat (9) @(posedge mclk_i);
    #1 chk(cfg_mode_o, 1'b1);
    chk(irq_o, 1'b0);
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    rchk(OFF_STATUS, 32'h01);
    rchk(OFF_IFLAGS, 32'h0);
    // mask readback, unmapped and write-only places
    mask_m = $urandom & 32'hfff;
    wr(OFF_IMASK, mask_m | ($urandom & 32'hfffff000));
    rchk(OFF_IMASK, mask_m);
    rchk(8'h14, 32'h0);
    rchk(OFF_ICLR, 32'h0);
    wr(OFF_IFLAGS, 32'hffffffff);
    rchk(OFF_IFLAGS, 32'h0);
    // normal mode, bus activity from either direction
    wr(OFF_CTRL, 32'h1);
    mode_m = 1;
    tick(2);
    rchk(OFF_STATUS, exp_st());
    chk(cfg_mode_o, 1'b0);
    @(posedge mclk_i);
    rx_busy_i <= 1'b1;
    busy_m = 1;
    tick(3);
    rchk(OFF_STATUS, exp_st());
    @(posedge mclk_i);
    rx_busy_i <= 1'b0;
    tx_busy_i <= 1'b1;
    tick(3);
    rchk(OFF_STATUS, exp_st());
    @(posedge mclk_i);
    tx_busy_i <= 1'b0;
    busy_m = 0;
    tick(3);
    // sleep and wake
    wr(OFF_CTRL, 32'h5);
    mode_m = 3;
    flags_m |= 1 << FL_DOZE;
    tick(2);
    rchk(OFF_STATUS, exp_st());
    chk(sleep_o, 1'b1);
    // bus traffic wakes the core, idle bus sends it back to sleep
    @(posedge mclk_i);
    rx_busy_i <= 1'b1;
    busy_m = 1;
    mode_m = 1;
    flags_m |= 1 << FL_WAKE;
    tick(3);
    rchk(OFF_STATUS, exp_st());
    @(posedge mclk_i);
    rx_busy_i <= 1'b0;
    busy_m = 0;
    mode_m = 3;
    tick(3);
    rchk(OFF_STATUS, exp_st());
    chk(sleep_o, 1'b1);
    wr(OFF_CTRL, 32'h1);
    mode_m = 1;
    flags_m |= 1 << FL_WAKE;
    tick(2);
    rchk(OFF_STATUS, exp_st());
    // loopback frame outside loopback mode sets nothing
    @(posedge mclk_i);
    lb_frame_i <= 1'b1;
    @(posedge mclk_i);
    lb_frame_i <= 1'b0;
    rchk(OFF_IFLAGS, flags_m);
    for (int b = 0; b < 10; b++) pulse(b);
    rchk(OFF_IFLAGS, flags_m);
    chk(irq_o, (flags_m & mask_m) != 0);
    // every flag reaches the one line, then clears
    for (int i = 0; i < NFLAG; i++) begin
      wr(OFF_IMASK, 1 << i);
      mask_m = 1 << i;
      tick(2);
      chk(irq_o, 1'b1);
      wr(OFF_ICLR, 1 << i);
      flags_m &= ~(1 << i);
      tick(2);
      chk(irq_o, 1'b0);
    end
    rchk(OFF_IFLAGS, 32'h0);
    // set and clear in one cycle
    pulse(FL_ARB);
    pulse(FL_PRIOFULL);
    @(posedge mclk_i);
    arb_lost_i <= 1'b1;
    wr_i <= 1'b1;
    addr_i <= OFF_ICLR;
    wdata_i <= 32'h9;
    @(posedge mclk_i);
    arb_lost_i <= 1'b0;
    wr_i <= 1'b0;
    flags_m = 1;
    rchk(OFF_IFLAGS, flags_m);
    // core disable clears only some flags
    for (int b = 0; b < 10; b++) pulse(b);
    wr(OFF_CTRL, 32'h0);
    mode_m = 0;
    flags_m &= 32'h0ac;
    tick(2);
    rchk(OFF_STATUS, exp_st());
    rchk(OFF_IFLAGS, flags_m);
    // loopback frame: received flag before sent flag
    wr(OFF_ICLR, 32'hfff);
    wr(OFF_CTRL, 32'h3);
    mode_m = 2;
    tick(2);
    rchk(OFF_STATUS, exp_st());
    chk(loopback_o, 1'b1);
    @(posedge mclk_i);
    lb_frame_i <= 1'b1;
    @(posedge mclk_i);
    lb_frame_i <= 1'b0;
    rd_i <= 1'b1;
    addr_i <= OFF_IFLAGS;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 chk(rdata_o, 32'h10);
    rchk(OFF_IFLAGS, 32'h12);
    // mid-run reset returns the mode outputs, irq_o and the status and flag registers to their reset values
    @(posedge mclk_i);
    reset_n_i <= 1'b0;
    tick(2);
    chk(cfg_mode_o, 1'b1);
    chk(loopback_o, 1'b0);
    chk(sleep_o, 1'b0);
    chk(irq_o, 1'b0);
    @(posedge mclk_i);
    reset_n_i <= 1'b1;
    mode_m = 0;
    busy_m = 0;
    flags_m = 0;
    rchk(OFF_STATUS, exp_st());
    rchk(OFF_IFLAGS, flags_m);
    wrap_up();
  end
endmodule : tb_top
